// ==== verilog/sbts_map.vh ====
// Constants for the sensor bus timing sequencer: bus address, commands, delays.
// Assumes the includer works at the core clock rate given by SBTS_CLK_MHZ.
`ifndef SBTS_MAP_VH
`define SBTS_MAP_VH

`define SBTS_CLK_MHZ        24'h0000fa
`define SBTS_DEV_ADDR       7'h70
`define SBTS_CMD_MEAS_CS_T  16'h7ca2
`define SBTS_CMD_MEAS_CS_H  16'h5c24
`define SBTS_CMD_MEAS_T     16'h7866
`define SBTS_CMD_MEAS_H     16'h58e0
`define SBTS_CMD_SOFT_RST   16'h805d
`define SBTS_CMD_READ_ID    16'hefc8
// Delays: power-up and soft reset in us, measurement in units of 0.1 ms; all 24 bits wide
`define SBTS_PU_TYP_US      24'h0000b6
`define SBTS_PU_MAX_US      24'h0000ef
`define SBTS_SR_TYP_US      24'h0000ad
`define SBTS_SR_MAX_US      24'h0000e6
`define SBTS_MEAS_TYP_100US 24'h00006c
`define SBTS_MEAS_MAX_100US 24'h000090
// Cycle counts; typical figures are used, each below its maximum
`define SBTS_PU_CYC         (`SBTS_PU_TYP_US * `SBTS_CLK_MHZ)
`define SBTS_SR_CYC         (`SBTS_SR_TYP_US * `SBTS_CLK_MHZ)
`define SBTS_MEAS_CYC       (`SBTS_MEAS_TYP_100US * 24'h000064 * `SBTS_CLK_MHZ)
`define SBTS_SAMP_BYTES     6

`endif

// ==== verilog/sbts_result_mem.v ====
// Small result memory: six bytes of measurement or ID readout, registered read.
// Assumes one writer and one reader on the core clock.
`timescale 1ns/1ps
`default_nettype none

module sbts_result_mem #(
	parameter DEPTH = 6,
	parameter AW    = 3
) (
	input  wire          clk_i,
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [7:0]    wdata_i,
	input  wire [AW-1:0] raddr_i,
	output reg  [7:0]    rdata_o
);
	reg [7:0] mem [0:DEPTH-1];

	// Write port and registered read port
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // sbts_result_mem

`default_nettype wire

// ==== verilog/sbts_sequencer.v ====
// Bus target and timing sequencer of a humidity/temperature sensor.
// Assumes pull-ups on both bus wires; the master only drives low.
// Functional notes
// (RULE_01) After power-on reset release the sensor is idle within 239 us (typ 182 us).
// (RULE_02) After acknowledging soft reset the sensor is idle within 230 us (typ 173 us).
// (RULE_03) A measurement completes within 14.4 ms (typ 10.8 ms).
// (RULE_04) The master keeps the clock between 0 and 400 kHz; any such rate works.
// (RULE_05) With stretching enabled the sensor may hold the clock low; the master waits.
// (RULE_06) The master only pulls the bus wires low and relies on pull-ups for high.
// (RULE_07) A measurement begins at the acknowledge of the last command byte.
// (RULE_08) While measuring, headers are not acknowledged unless stretching was chosen.
// (RULE_09) With stretching, a read header while measuring is acked and the clock held low.
// (RULE_10) Soft reset while idle reinitialises state and reloads calibration.
// (RULE_11) Delays are timed by counters sized for their maximum values.
`timescale 1ns/1ps
`default_nettype none
`include "sbts_map.vh"

module sbts_sequencer #(
	parameter [23:0] PU_CYC   = `SBTS_PU_CYC,
	parameter [23:0] SR_CYC   = `SBTS_SR_CYC,
	parameter [23:0] MEAS_CYC = `SBTS_MEAS_CYC,
	parameter [15:0] ID_WORD  = 16'h0007 // Arbitrary value
) (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        scl_i,
	output wire        scl_o,
	output wire        scl_oe_o,
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe_o,
	input  wire [15:0] hum_i,
	input  wire [15:0] temp_i,
	output reg         idle_o,
	output reg         measuring_o,
	output reg         calib_load_o
);
	localparam ST_PWR  = 3'd0;
	localparam ST_IDLE = 3'd1;
	localparam ST_MEAS = 3'd2;
	localparam ST_SRST = 3'd3;
	localparam BS_IDLE = 3'd0;
	localparam BS_ADDR = 3'd1;
	localparam BS_WR   = 3'd2;
	localparam BS_RD   = 3'd3;
	localparam BS_MACK = 3'd4;
	localparam BS_IGN  = 3'd5;

	// CRC-8, polynomial 0x31, init 0xff over two bytes
	function [7:0] crc8;
		input [15:0] d;
		integer i;
		reg [7:0] c;
		begin
			c = 8'hff;
			for (i = 15; i >= 0; i = i - 1) begin
				if (c[7] ^ d[i])
					c = {c[6:0], 1'b0} ^ 8'h31;
				else
					c = {c[6:0], 1'b0};
			end
			crc8 = c;
		end
	endfunction

	// Two-stage synchronisers for both bus wires
	reg [1:0] scl_s_q;
	reg [1:0] sda_s_q;
	reg       scl_d1_q;
	reg       sda_d1_q;
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_s_q  <= 2'b11;
			sda_s_q  <= 2'b11;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_s_q  <= {scl_s_q[0], scl_i};
			sda_s_q  <= {sda_s_q[0], sda_i};
			scl_d1_q <= scl_s_q[1];
			sda_d1_q <= sda_s_q[1];
		end
	end
	wire scl_w  = scl_s_q[1];
	wire sda_w  = sda_s_q[1];
	wire scl_r  = scl_w & ~scl_d1_q;
	wire scl_f  = ~scl_w & scl_d1_q;
	wire start  = scl_w & scl_d1_q & ~sda_w & sda_d1_q;
	wire stop   = scl_w & scl_d1_q & sda_w & ~sda_d1_q;

	reg  [2:0]  st_q;
	reg  [23:0] tmr_q;
	reg         stretch_q;
	reg  [2:0]  bs_q;
	reg  [3:0]  bit_q;
	reg  [7:0]  sh_q;
	reg         ack_q;
	reg         ack_done_q;
	reg         cmd_hi_q;
	reg  [7:0]  cmd_h_q;
	reg  [1:0]  wcnt_q;
	reg         hold_q;
	reg  [2:0]  rp_q;
	reg  [2:0]  wp_q;
	reg         we_q;
	reg  [7:0]  wd_q;
	reg         sda_low_q;
	wire [7:0]  rd_w;
	wire [15:0] cmd_w = {cmd_h_q, sh_q};
	wire        meas  = (st_q == ST_MEAS);

	sbts_result_mem #(.DEPTH(`SBTS_SAMP_BYTES), .AW(3)) u_mem (
		.clk_i   (clk_i),
		.we_i    (we_q),
		.waddr_i (wp_q),
		.wdata_i (wd_q),
		.raddr_i (rp_q),
		.rdata_o (rd_w)
	);

	// Clock stretch and bus drive; high comes from pull-ups only
	assign scl_o    = 1'b0;
	assign scl_oe_o = hold_q & ~scl_w; // RULE_05
	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_low_q;

	// Sequencer and bus target
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= ST_PWR; tmr_q <= 24'h0; stretch_q <= 1'b0; bs_q <= BS_IDLE;
			bit_q <= 4'h0; sh_q <= 8'h0; ack_q <= 1'b0; ack_done_q <= 1'b0;
			cmd_hi_q <= 1'b0; cmd_h_q <= 8'h0; wcnt_q <= 2'd0; hold_q <= 1'b0;
			rp_q <= 3'd0; wp_q <= 3'd0; we_q <= 1'b0; wd_q <= 8'h0;
			sda_low_q <= 1'b0; idle_o <= 1'b0; measuring_o <= 1'b0;
			calib_load_o <= 1'b0;
		end else begin
			we_q         <= 1'b0;
			calib_load_o <= 1'b0;
			idle_o       <= (st_q == ST_IDLE);
			measuring_o  <= meas;
			case (st_q)
				ST_PWR, ST_SRST: begin
					tmr_q <= tmr_q + 24'd1; // RULE_11
					if (tmr_q >= ((st_q == ST_PWR) ? PU_CYC : SR_CYC)) begin // RULE_01 RULE_02
						st_q <= ST_IDLE;
						tmr_q <= 24'h0;
					end
				end
				ST_MEAS: begin
					tmr_q <= tmr_q + 24'd1;
					if (tmr_q >= MEAS_CYC) begin // RULE_03
						st_q <= ST_IDLE;
						tmr_q <= 24'h0;
						hold_q <= 1'b0; // RULE_09
					end
					// Fill results: order chosen by the command's second bit pattern
					if (tmr_q[2:0] == 3'd0 && tmr_q[23:3] < 21'd6) begin
						we_q <= 1'b1;
						wp_q <= tmr_q[5:3];
						case (tmr_q[5:3])
							3'd0: wd_q <= ack_done_q ? hum_i[15:8] : temp_i[15:8];
							3'd1: wd_q <= ack_done_q ? hum_i[7:0] : temp_i[7:0];
							3'd2: wd_q <= crc8(ack_done_q ? hum_i : temp_i);
							3'd3: wd_q <= ack_done_q ? temp_i[15:8] : hum_i[15:8];
							3'd4: wd_q <= ack_done_q ? temp_i[7:0] : hum_i[7:0];
							default: wd_q <= crc8(ack_done_q ? temp_i : hum_i);
						endcase
					end
				end
				default: tmr_q <= 24'h0;
			endcase

			// Bus protocol on synchronised edges
			if (start) begin
				bs_q <= (st_q == ST_PWR || st_q == ST_SRST) ? BS_IGN : BS_ADDR;
				bit_q <= 4'd0; sda_low_q <= 1'b0; ack_q <= 1'b0;
			end else if (stop) begin
				bs_q <= BS_IDLE; sda_low_q <= 1'b0; cmd_hi_q <= 1'b0;
			end else if (scl_r && (bs_q == BS_ADDR || bs_q == BS_WR) && !ack_q) begin
				sh_q <= {sh_q[6:0], sda_w};
				bit_q <= bit_q + 4'd1;
			end else if (scl_r && bs_q == BS_MACK) begin
				bs_q <= sda_w ? BS_IGN : BS_RD; // Master NACK ends readout
				if (rp_q == 3'd5) bs_q <= BS_IGN;
				else rp_q <= rp_q + 3'd1;
				bit_q <= 4'd0;
			end else if (scl_f) begin
				if (ack_q) begin
					ack_q <= 1'b0;
					sda_low_q <= 1'b0;
					bit_q <= 4'd0;
					if (bs_q == BS_RD) begin
						sda_low_q <= ~rd_w[7];
						sh_q <= {rd_w[6:0], 1'b0};
						bit_q <= 4'd1;
					end
				end else if (bs_q == BS_RD) begin
					if (bit_q == 4'd8) begin
						sda_low_q <= 1'b0;
						bs_q <= BS_MACK;
					end else if (bit_q == 4'd0) begin
						// Byte after a master ACK comes fresh from the memory
						sda_low_q <= ~rd_w[7];
						sh_q <= {rd_w[6:0], 1'b0};
						bit_q <= 4'd1;
					end else begin
						sda_low_q <= ~sh_q[7];
						sh_q <= {sh_q[6:0], 1'b0};
						bit_q <= bit_q + 4'd1;
					end
				end else if (bit_q == 4'd8 && bs_q == BS_ADDR) begin
					if (sh_q[7:1] == `SBTS_DEV_ADDR && (!meas || (stretch_q && sh_q[0]))) begin // RULE_08
						ack_q <= 1'b1;
						sda_low_q <= 1'b1;
						bs_q <= sh_q[0] ? BS_RD : BS_WR;
						rp_q <= 3'd0;
						cmd_hi_q <= 1'b0;
						hold_q <= meas & sh_q[0]; // RULE_09
					end else begin
						bs_q <= BS_IGN;
					end
				end else if (bit_q == 4'd8 && bs_q == BS_WR) begin
					ack_q <= 1'b1;
					sda_low_q <= 1'b1;
					if (!cmd_hi_q) begin
						cmd_h_q <= sh_q;
						cmd_hi_q <= 1'b1;
					end else begin
						cmd_hi_q <= 1'b0;
						if (cmd_w == `SBTS_CMD_MEAS_CS_T || cmd_w == `SBTS_CMD_MEAS_CS_H ||
							cmd_w == `SBTS_CMD_MEAS_T || cmd_w == `SBTS_CMD_MEAS_H) begin
							st_q <= ST_MEAS; // RULE_07
							tmr_q <= 24'h0;
							stretch_q <= (cmd_w == `SBTS_CMD_MEAS_CS_T) ||
								(cmd_w == `SBTS_CMD_MEAS_CS_H);
							ack_done_q <= (cmd_w == `SBTS_CMD_MEAS_CS_H) ||
								(cmd_w == `SBTS_CMD_MEAS_H);
						end else if (cmd_w == `SBTS_CMD_SOFT_RST && st_q == ST_IDLE) begin
							st_q <= ST_SRST; // RULE_10
							tmr_q <= 24'h0;
							calib_load_o <= 1'b1;
							stretch_q <= 1'b0;
						end else if (cmd_w == `SBTS_CMD_READ_ID) begin
							we_q <= 1'b1;
							wp_q <= 3'd0;
							wd_q <= ID_WORD[15:8];
							cmd_h_q <= ID_WORD[7:0];
						end
					end
				end
			end
			// Second ID byte and CRC written on the following cycles
			if (we_q && !meas && wp_q == 3'd0 && wd_q == ID_WORD[15:8]) begin
				we_q <= 1'b1; wp_q <= 3'd1; wd_q <= ID_WORD[7:0];
			end else if (we_q && !meas && wp_q == 3'd1 && wd_q == ID_WORD[7:0]) begin
				we_q <= 1'b1; wp_q <= 3'd2; wd_q <= crc8(ID_WORD);
			end
		end
	end
endmodule // sbts_sequencer

`default_nettype wire

// ==== test/sbts_chk_checker.sv ====
// Checker: delay windows and pin drive of the sequencer.
// Assumes it is bound to sbts_sequencer with the bench's delay parameters.
`timescale 1ns/1ps
`default_nettype none
module sbts_chk #(
	parameter [23:0] PU_CYC   = 24'd200,
	parameter [23:0] MEAS_CYC = 24'd2000
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic idle_o,
	input wire logic measuring_o,
	input wire logic calib_load_o
);
	logic [23:0] up_q;
	logic [23:0] ms_q;
	// Cycles since reset release and since measurement start
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			up_q <= 24'h0;
			ms_q <= 24'h0;
		end else begin
			up_q <= (up_q > PU_CYC + 24'h8) ? up_q : up_q + 24'h1;
			ms_q <= measuring_o ? ms_q + 24'h1 : 24'h0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	pu_early_a: assert property (up_q < PU_CYC |-> !idle_o)
		else $error("idle too early");
	pu_late_a: assert property (up_q == PU_CYC + 24'h8 |-> idle_o || measuring_o)
		else $error("idle too late");
	meas_max_a: assert property (measuring_o |-> ms_q <= MEAS_CYC + 24'h4)
		else $error("measurement too long");
	meas_min_a: assert property ($fell(measuring_o) |-> $past(ms_q) + 24'h3 >= MEAS_CYC)
		else $error("measurement too short");
	meas_ack_a: assert property ($rose(measuring_o) |-> sda_oe_o)
		else $error("measurement not at ack");
	stretch_a: assert property (scl_oe_o |-> measuring_o || $past(measuring_o))
		else $error("clock held outside measurement");
	sda_turn_a: assert property ($changed(sda_oe_o) |-> !scl_i && !sda_o && !scl_o)
		else $error("data drive changed while clock high");
	cal_pulse_a: assert property (calib_load_o |=> !calib_load_o && !measuring_o)
		else $error("calibration load not a pulse");
	sr_bound_a: assert property (calib_load_o |-> ##[1:216] idle_o)
		else $error("soft reset too long");
	cover property ($rose(measuring_o));
	cover property ($rose(scl_oe_o));
	cover property (calib_load_o);
endmodule // sbts_chk
bind sbts_sequencer sbts_chk #(.PU_CYC(PU_CYC), .MEAS_CYC(MEAS_CYC)) chk (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.idle_o(idle_o), .measuring_o(measuring_o), .calib_load_o(calib_load_o));
`default_nettype wire

// ==== test/sbts_mm.sv ====
// Bus master model: bit-level open-drain driver, 125 ns bit period.
// Assumes pull-ups resolve both wires outside.
`timescale 1ns/1ps
`default_nettype none
module sbts_mm (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic scl_dn_o,
	output var  logic sda_dn_o,
	output var  logic hung_o
);
	initial begin
		scl_dn_o = 1'b0;
		sda_dn_o = 1'b0;
		hung_o = 1'b0;
	end
	// Quarter bit period
	task automatic q;
		#31.25;
	endtask
	// One bit; only ever pulls low, waits out a held clock
	task automatic bx(input logic b, output logic r);
		int n;
		sda_dn_o = !b;
		q();
		scl_dn_o = 1'b0;
		n = 0;
		while (!scl_i && n < 5000) begin
			#4;
			n++;
		end
		hung_o = hung_o | (n == 5000);
		q();
		r = sda_i;
		q();
		scl_dn_o = 1'b1;
		q();
	endtask
	task automatic start;
		sda_dn_o = 1'b1;
		q();
		scl_dn_o = 1'b1;
		q();
	endtask
	task automatic stop;
		sda_dn_o = 1'b1;
		q();
		scl_dn_o = 1'b0;
		q();
		sda_dn_o = 1'b0;
		q();
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bx(d[i], r);
		bx(1'b1, r);
		ack = !r;
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
		bx(last, r);
	endtask
endmodule // sbts_mm
`default_nettype wire

// ==== test/test_sbts_sequencer.sv ====
// Bench: power-up, all measurement commands, soft reset, refusals.
// Assumes the bus model and bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "sbts_map.vh"
module test_sbts_sequencer;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [15:0] hum_i = 16'h6a3c;
	logic [15:0] temp_i = 16'hbeef;
	wire logic   scl, sda, scl_oe, sda_oe, scl_dn, sda_dn, hung, idle, meas, cal;
	int          errors = 0;
	int          compares = 0;
	int          cal_n = 0;
	localparam logic [15:0] ID = 16'h3a5c; // Arbitrary value
	always #2 clk_i = ~clk_i;
	// Pull-ups: a wire is low while any party pulls it
	assign scl = ~(scl_oe | scl_dn);
	assign sda = ~(sda_oe | sda_dn);
	always @(posedge clk_i) cal_n <= cal_n + int'(cal === 1'b1);
	sbts_sequencer #(.PU_CYC(24'd200), .SR_CYC(24'd200), .MEAS_CYC(24'd2000),
		.ID_WORD(ID)) dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .hum_i(hum_i), .temp_i(temp_i),
		.idle_o(idle), .measuring_o(meas), .calib_load_o(cal));
	sbts_mm mm (.scl_i(scl), .sda_i(sda), .scl_dn_o(scl_dn), .sda_dn_o(sda_dn), .hung_o(hung));
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		if (errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wait_idle(output int n);
		n = 0;
		while (idle !== 1'b1 && n < 20000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n == 20000) begin
			errors++;
			close_out();
		end
	endtask
	function automatic logic [7:0] crc(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
		return c;
	endfunction
	// Write header and two command bytes; e holds the three expected acks
	task automatic send(input logic [15:0] c, input logic [2:0] e);
		logic [2:0] a;
		mm.start();
		mm.wr({`SBTS_DEV_ADDR, 1'b0}, a[2]);
		mm.wr(c[15:8], a[1]);
		mm.wr(c[7:0], a[0]);
		mm.stop();
		cmp("cmd acks", {13'h0, e}, {13'h0, a});
	endtask
	task automatic read6(input logic [15:0] w1, input logic [15:0] w2);
		logic [7:0] b[6];
		logic a;
		mm.start();
		mm.wr({`SBTS_DEV_ADDR, 1'b1}, a);
		for (int i = 0; i < 6; i++) mm.rd(i == 5, b[i]);
		mm.stop();
		cmp("read ack", 16'h1, {15'h0, a});
		cmp("word one", w1, {b[0], b[1]});
		cmp("crcs", {crc(w1), crc(w2)}, {b[2], b[5]});
		cmp("word two", w2, {b[3], b[4]});
	endtask
	// Every measurement command; busy header refused without stretching
	task automatic t_meas;
		logic [15:0] cmds[4] = '{`SBTS_CMD_MEAS_CS_T, `SBTS_CMD_MEAS_CS_H,
			`SBTS_CMD_MEAS_T, `SBTS_CMD_MEAS_H};
		int n;
		logic a;
		for (int k = 0; k < 4; k++) begin
			send(cmds[k], 3'b111);
			cmp("measuring", 16'h1, {15'h0, meas});
			if (k >= 2) begin
				mm.start();
				mm.wr({`SBTS_DEV_ADDR, 1'b1}, a);
				mm.stop();
				cmp("busy nack", 16'h0, {15'h0, a});
				wait_idle(n);
			end
			read6(k[0] ? hum_i : temp_i, k[0] ? temp_i : hum_i);
		end
	endtask
	// Soft reset refused while measuring, taken when idle
	task automatic t_reset;
		int n;
		int c0;
		send(`SBTS_CMD_MEAS_T, 3'b111);
		c0 = cal_n;
		send(`SBTS_CMD_SOFT_RST, 3'b000);
		wait_idle(n);
		cmp("no reload", 16'h0, 16'(cal_n - c0));
		send(`SBTS_CMD_SOFT_RST, 3'b111);
		wait_idle(n);
		cmp("reload", 16'h1, 16'(cal_n - c0));
	endtask
	// Identification readout: word and its check byte, last byte not acknowledged
	task automatic t_id;
		logic [7:0] b[3];
		logic a;
		send(`SBTS_CMD_READ_ID, 3'b111);
		mm.start();
		mm.wr({`SBTS_DEV_ADDR, 1'b1}, a);
		for (int i = 0; i < 3; i++) mm.rd(i == 2, b[i]);
		mm.stop();
		cmp("id ack", 16'h1, {15'h0, a});
		cmp("id word", ID, {b[0], b[1]});
		cmp("id crc", {8'h0, crc(ID)}, {8'h0, b[2]});
	endtask
	initial begin
		int n;
		repeat (6) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		wait_idle(n);
		cmp("power-up", 16'h1, {15'h0, n >= 200 && n <= 205});
		t_meas();
		t_reset();
		t_id();
		cmp("clock hold", 16'h0, {15'h0, hung});
		close_out();
	end
endmodule // test_sbts_sequencer
`default_nettype wire
